//--- verilog/i2cscp_pkg.sv
package i2cscp_pkg;
	// ****************************************
	// slave address and port selection
	// ****************************************
	localparam logic [3:0] I2CSCP_ADDR_HIGH  = 4'hB;
	localparam logic [1:0] I2CSCP_PIN_LOW    = 2'h0;
	localparam logic [1:0] I2CSCP_PIN_OPEN   = 2'h1;
	localparam logic [1:0] I2CSCP_PIN_HIGH   = 2'h2;
	// ****************************************
	// byte framing and reset values
	// ****************************************
	localparam logic [3:0] I2CSCP_ACK_BIT    = 4'h8;
	localparam logic [3:0] I2CSCP_BIT_RESET  = 4'h0;
	localparam logic [15:0] I2CSCP_PTR_RESET = 16'h0000;
	localparam int         I2CSCP_FIFO_DEPTH = 32;
	localparam int         I2CSCP_DATA_W     = 8;

	typedef enum logic [2:0] {
		I2CSCP_IDLE,
		I2CSCP_ADDR,
		I2CSCP_PTR_HI,
		I2CSCP_PTR_LO,
		I2CSCP_WDATA,
		I2CSCP_RDATA
	} i2cscp_state_type;
endpackage

//--- verilog/i2cscp_fifo.sv
`timescale 1ns/1ps
module i2cscp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_idx;
	logic [AW-1:0]    rd_idx;
	logic [AW:0]      count;
	logic [AW-1:0]    next_wr_idx;
	logic [AW-1:0]    next_rd_idx;
	logic [AW:0]      next_count;
	logic             push;
	logic             pop;

	always_comb begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		next_wr_idx = wr_idx;
		next_rd_idx = rd_idx;
		if (push) begin
			next_wr_idx = (wr_idx == AW'(DEPTH - 1)) ? '0 : AW'(wr_idx + 1'b1);
		end
		if (pop) begin
			next_rd_idx = (rd_idx == AW'(DEPTH - 1)) ? '0 : AW'(rd_idx + 1'b1);
		end
		next_count = (AW + 1)'(count + (AW + 1)'(push) - (AW + 1)'(pop));
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_idx <= '0;
			rd_idx <= '0;
			count <= '0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
		end else begin
			wr_idx <= next_wr_idx;
			rd_idx <= next_rd_idx;
			count <= next_count;
			in_ready <= next_count != (AW + 1)'(DEPTH);
			out_valid <= next_count != '0;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_idx] <= in_data;
		end
	end

	assign out_data = mem[rd_idx];
endmodule // i2cscp_fifo

//--- verilog/i2cscp_top.sv
// Overview of operation
// - sda changes only while scl low
// - sda falling with scl high starts
// - sda rising with scl high stops
// - eight bits msb first, then ack
// - receiver acks by holding sda low
// - nack leaves sda released high
// - first byte: address plus direction bit
// - ack own address only, else idle
// - write: pointer high then low byte
// - following write bytes stored and acked while the buffer has room, else nacked
// - read sends data right after address ack
// - master nack ends read, release sda
// - restart allowed; partial byte discarded
// - pointer-only write just sets pointer
// - plain read starts at held pointer
// - combined write-restart-read supported
// - address is 1011 plus pin code
// - both select pins high disables port
`timescale 1ns/1ps
module i2cscp_top
	import i2cscp_pkg::*;
#(
	parameter int DATA_W = I2CSCP_DATA_W,
	parameter int DEPTH  = I2CSCP_FIFO_DEPTH
) (
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic              scl,
	input  wire logic              sda_in,
	output logic                   sda_out,
	output logic                   sda_oe,
	input  wire logic [1:0]        port_select_pin_high,
	input  wire logic [1:0]        port_select_pin_low,
	output logic                   port_active,
	output logic      [15:0]       reg_addr,
	output logic      [DATA_W-1:0] reg_wdata,
	output logic                   reg_wvalid,
	input  wire logic              reg_wready,
	output logic                   reg_rd,
	input  wire logic [DATA_W-1:0] reg_rdata
);
	// ****************************************
	// bus edge and condition detection
	// ****************************************
	logic scl_q;
	logic sda_q;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic [6:0] own_addr;
	logic next_port_active;

	always_comb begin
		scl_rise = scl && !scl_q;
		scl_fall = !scl && scl_q;
		start_det = scl && scl_q && sda_q && !sda_in;
		stop_det = scl && scl_q && !sda_q && sda_in;
		// pin code: low/open/high pairs give 0..7
		own_addr = {I2CSCP_ADDR_HIGH,
			3'(3'(port_select_pin_high) * 3'h3 + 3'(port_select_pin_low))};
		next_port_active = !(port_select_pin_high == I2CSCP_PIN_HIGH
			&& port_select_pin_low == I2CSCP_PIN_HIGH);
	end

	// ****************************************
	// protocol state
	// ****************************************
	i2cscp_state_type state;
	i2cscp_state_type next_state;
	logic [3:0]  bit_cnt;
	logic [3:0]  next_bit_cnt;
	logic [7:0]  shift;
	logic [7:0]  next_shift;
	logic [15:0] next_reg_addr;
	logic        next_sda_out;
	logic        next_sda_oe;
	logic        next_reg_rd;
	logic        read_dir;
	logic        next_read_dir;
	logic        nacked;
	logic        next_nacked;
	logic        byte_push;
	logic [7:0]  push_data;
	logic        fifo_ready;
	logic        rd_wait;
	logic        next_rd_wait;
	logic        after_start;
	logic        next_after_start;

	always_comb begin
		next_state = state;
		next_bit_cnt = bit_cnt;
		next_shift = shift;
		next_reg_addr = reg_addr;
		next_sda_out = sda_out;
		next_sda_oe = sda_oe;
		next_read_dir = read_dir;
		next_nacked = nacked;
		next_reg_rd = 1'b0;
		next_rd_wait = rd_wait;
		next_after_start = after_start;
		byte_push = 1'b0;
		push_data = shift;
		if (!port_active) begin
			next_state = I2CSCP_IDLE;
			next_sda_oe = 1'b0;
			next_rd_wait = 1'b0;
			next_after_start = 1'b0;
		end else if (start_det) begin
			next_state = I2CSCP_ADDR;
			next_bit_cnt = I2CSCP_BIT_RESET;
			next_sda_oe = 1'b0;
			next_rd_wait = 1'b0;
			next_after_start = 1'b1;
		end else if (stop_det) begin
			next_state = I2CSCP_IDLE;
			next_sda_oe = 1'b0;
			next_rd_wait = 1'b0;
			next_after_start = 1'b0;
		end else if (rd_wait) begin
			// data from register port is taken in the same cycle as the reg_rd request
			next_rd_wait = 1'b0;
			next_shift = reg_rdata;
			next_sda_oe = !reg_rdata[7];
			next_sda_out = 1'b0;
		end else if (state != I2CSCP_IDLE && scl_rise && bit_cnt < I2CSCP_ACK_BIT) begin
			if (state != I2CSCP_RDATA) begin
				next_shift = {shift[6:0], sda_in};
			end
		end else if (state != I2CSCP_IDLE && scl_rise) begin
			next_nacked = sda_in;
		end else if (after_start && scl_fall) begin
			// scl fall closing the start is not a bit
			next_after_start = 1'b0;
		end else if (state != I2CSCP_IDLE && scl_fall) begin
			next_bit_cnt = (bit_cnt == I2CSCP_ACK_BIT) ? I2CSCP_BIT_RESET : 4'(bit_cnt + 1'b1);
			next_sda_oe = 1'b0;
			next_sda_out = 1'b0;
			if (bit_cnt == 4'h7) begin
				// eighth bit done: decide acknowledge
				if (state == I2CSCP_ADDR) begin
					if (shift[7:1] == own_addr) begin
						next_sda_oe = 1'b1;
						next_read_dir = shift[0];
					end else begin
						next_state = I2CSCP_IDLE;
					end
				end else if (state == I2CSCP_RDATA) begin
					next_reg_addr = 16'(reg_addr + 1'b1);
				end else if (state == I2CSCP_WDATA) begin
					next_sda_oe = fifo_ready;
					byte_push = fifo_ready;
				end else begin
					next_sda_oe = 1'b1;
				end
				if (state == I2CSCP_PTR_HI) begin
					next_reg_addr = {shift, reg_addr[7:0]};
				end else if (state == I2CSCP_PTR_LO) begin
					next_reg_addr = {reg_addr[15:8], shift};
				end
			end else if (bit_cnt == I2CSCP_ACK_BIT) begin
				unique case (state)
					I2CSCP_ADDR: begin
						next_state = read_dir ? I2CSCP_RDATA : I2CSCP_PTR_HI;
						next_reg_rd = read_dir;
						next_rd_wait = read_dir;
					end
					I2CSCP_PTR_HI: next_state = I2CSCP_PTR_LO;
					I2CSCP_PTR_LO: next_state = I2CSCP_WDATA;
					I2CSCP_WDATA:  next_state = I2CSCP_WDATA;
					I2CSCP_RDATA: begin
						if (nacked) begin
							next_state = I2CSCP_IDLE;
						end else begin
							next_reg_rd = 1'b1;
							next_rd_wait = 1'b1;
						end
					end
					I2CSCP_IDLE: next_state = I2CSCP_IDLE;
				endcase
			end else if (state == I2CSCP_RDATA) begin
				next_shift = {shift[6:0], 1'b0};
				next_sda_oe = !shift[6];
			end
		end
		if (byte_push) begin
			next_reg_addr = 16'(reg_addr + 1'b1);
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			port_active <= 1'b0;
			state <= I2CSCP_IDLE;
			bit_cnt <= I2CSCP_BIT_RESET;
			shift <= 8'h00;
			reg_addr <= I2CSCP_PTR_RESET;
			sda_out <= 1'b0;
			sda_oe <= 1'b0;
			read_dir <= 1'b0;
			nacked <= 1'b0;
			reg_rd <= 1'b0;
			rd_wait <= 1'b0;
			after_start <= 1'b0;
		end else begin
			scl_q <= scl;
			sda_q <= sda_in;
			port_active <= next_port_active;
			state <= next_state;
			bit_cnt <= next_bit_cnt;
			shift <= next_shift;
			reg_addr <= next_reg_addr;
			sda_out <= next_sda_out;
			sda_oe <= next_sda_oe;
			read_dir <= next_read_dir;
			nacked <= next_nacked;
			reg_rd <= next_reg_rd;
			rd_wait <= next_rd_wait;
			after_start <= next_after_start;
		end
	end

	// ****************************************
	// write data buffer
	// ****************************************
	logic [DATA_W-1:0] fifo_data;
	logic              fifo_valid;

	i2cscp_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst_b     (rst_b),
		.in_data   (DATA_W'(push_data)),
		.in_valid  (byte_push),
		.in_ready  (fifo_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (reg_wready && !reg_wvalid)
	);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_wdata <= '0;
			reg_wvalid <= 1'b0;
		end else begin
			reg_wvalid <= fifo_valid && reg_wready && !reg_wvalid;
			reg_wdata <= fifo_data;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	property p_ack_own;
		@(posedge clk) disable iff (!rst_b)
		(state == I2CSCP_ADDR && scl_fall && bit_cnt == 4'h7 && shift[7:1] == own_addr
			&& port_active && !start_det && !stop_det && !rd_wait) |=> sda_oe;
	endproperty
	a_ack_own: assert property (p_ack_own) else $error("own address not acked");

	property p_idle_quiet;
		@(posedge clk) disable iff (!rst_b)
		(state == I2CSCP_IDLE) |-> !sda_oe;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("sda driven while idle");

	property p_stop_idle;
		@(posedge clk) disable iff (!rst_b)
		(stop_det && !start_det) |=> (state == I2CSCP_IDLE && !sda_oe);
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("stop not honoured");

	property p_start_addr;
		@(posedge clk) disable iff (!rst_b)
		(start_det && port_active) |=> (state == I2CSCP_ADDR && bit_cnt == I2CSCP_BIT_RESET);
	endproperty
	a_start_addr: assert property (p_start_addr) else $error("start not honoured");

	property p_stable_high;
		@(posedge clk) disable iff (!rst_b)
		(scl && scl_q) |-> $stable(sda_oe) || stop_det || start_det || $past(start_det) || $past(stop_det);
	endproperty
	a_stable_high: assert property (p_stable_high) else $error("sda moved with scl high");

	property p_spi_off;
		@(posedge clk) disable iff (!rst_b)
		!port_active |=> !sda_oe;
	endproperty
	a_spi_off: assert property (p_spi_off) else $error("port active in spi mode");

	property p_ptr_inc;
		@(posedge clk) disable iff (!rst_b)
		byte_push |=> reg_addr == 16'($past(reg_addr) + 1'b1);
	endproperty
	a_ptr_inc: assert property (p_ptr_inc) else $error("pointer not incremented");

	property p_nack_end;
		@(posedge clk) disable iff (!rst_b)
		(state == I2CSCP_RDATA && scl_fall && bit_cnt == I2CSCP_ACK_BIT && nacked && port_active
			&& !start_det && !stop_det && !rd_wait) |=> (state == I2CSCP_IDLE && !sda_oe);
	endproperty
	a_nack_end: assert property (p_nack_end) else $error("read not ended on nack");

	c_write: cover property (@(posedge clk) disable iff (!rst_b) byte_push);
	c_read: cover property (@(posedge clk) disable iff (!rst_b) reg_rd);
	c_restart: cover property (@(posedge clk) disable iff (!rst_b)
		start_det && state == I2CSCP_WDATA);
endmodule // i2cscp_top

//--- bench/i2cscp_master.sv
`timescale 1ns/1ps
module i2cscp_master (
	input  wire logic clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_pull
);
	// ****************************************
	// bus master, open-drain data pull
	// ****************************************
	localparam int HALF = 5;

	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic start();
		sda_pull <= 1'b0;
		tick(HALF);
		scl <= 1'b1;
		tick(HALF);
		sda_pull <= 1'b1;
		tick(HALF);
		scl <= 1'b0;
		tick(1);
	endtask

	task automatic stop();
		sda_pull <= 1'b1;
		tick(HALF);
		scl <= 1'b1;
		tick(HALF);
		sda_pull <= 1'b0;
		tick(HALF);
	endtask

	task automatic bitx(input logic b, output logic r);
		sda_pull <= ~b;
		tick(HALF);
		scl <= 1'b1;
		tick(HALF - 2);
		#1 r = sda;
		tick(2);
		scl <= 1'b0;
		tick(1);
	endtask

	task automatic xfer(input logic [7:0] d, input int n, output logic [7:0] r);
		r = 8'h00;
		for (int i = 7; i > 7 - n; i--) begin
			bitx(d[i], r[i]);
		end
	endtask

	task automatic ack(input logic give, output logic seen);
		bitx(~give, seen);
		seen = ~seen;
	endtask
endmodule // i2cscp_master

//--- bench/test_i2c_slave_control_port.sv
`timescale 1ns/1ps
module test_i2c_slave_control_port
	import i2cscp_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        reg_wready = 1'b1;
	logic        hold_low = 1'b0;
	logic [1:0]  port_select_pin_high = 2'h0;
	logic [1:0]  port_select_pin_low = 2'h0;
	logic [7:0]  reg_rdata = 8'h00;
	wire         sda_out, sda_oe, port_active, reg_wvalid, reg_rd, scl, sda_pull;
	wire  [15:0] reg_addr;
	wire  [7:0]  reg_wdata;
	wire         sda = !(sda_pull || (sda_oe && !sda_out));
	logic [7:0]  mem [int];
	logic [23:0] wq [$];
	logic [23:0] e;
	logic [15:0] exp_ptr = 16'h0000;
	logic [6:0]  dev = 7'h00;
	logic [31:0] rs = 32'hA57A08FD;
	logic [31:0] ws = 32'hA57A08FD;
	logic [7:0]  r;
	int          n_mismatch = 0;
	int          num_checks = 0;
	int          cyc = 0;
	int          n_rd = 0;
	int          n;

	i2cscp_master m (.clk(clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));

	i2cscp_top uut (.clk(clk), .rst_b(rst_b), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.port_select_pin_high(port_select_pin_high), .port_select_pin_low(port_select_pin_low),
		.port_active(port_active), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wvalid(reg_wvalid),
		.reg_wready(reg_wready), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

	initial begin
		forever #25 clk = ~clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [7:0] rd_val(input logic [15:0] a);
		return mem.exists(a) ? mem[a] : a[7:0] ^ a[15:8] ^ 8'hA5;
	endfunction

	task automatic conclude();
		if (n_mismatch == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_ack(input logic got, input logic exp);
		chk_val({15'h0000, got}, {15'h0000, exp});
	endtask

	task automatic sendb(input logic [7:0] d, output logic a);
		logic [7:0] x;
		m.xfer(d, 8, x);
		m.ack(1'b0, a);
	endtask

	task automatic set_ptr(input logic [15:0] p);
		logic a;
		m.start();
		sendb({dev, 1'b0}, a);
		chk_ack(a, 1'b1);
		sendb(p[15:8], a);
		chk_ack(a, 1'b1);
		sendb(p[7:0], a);
		chk_ack(a, 1'b1);
		chk_val(reg_addr, p);
		exp_ptr = p;
	endtask

	task automatic wr_data(input int cnt, output int acked);
		logic a;
		acked = 0;
		for (int i = 0; i < cnt; i++) begin
			rs = lfsr(rs);
			wq.push_back({exp_ptr, rs[7:0]});
			sendb(rs[7:0], a);
			if (!a) begin
				void'(wq.pop_back());
				break;
			end
			exp_ptr++;
			acked++;
		end
	endtask

	task automatic rd_data(input int cnt);
		logic       a;
		logic [7:0] d;
		int         rd0;
		rd0 = n_rd;
		m.start();
		sendb({dev, 1'b1}, a);
		chk_ack(a, 1'b1);
		for (int i = 0; i < cnt; i++) begin
			m.xfer(8'hFF, 8, d);
			m.ack(i != cnt - 1, a);
			chk_val({8'h00, d}, {8'h00, rd_val(exp_ptr)});
			exp_ptr++;
		end
		m.stop();
		chk_val(16'(n_rd - rd0), 16'(cnt));
		chk_val(reg_addr, exp_ptr);
	endtask

	task automatic drain();
		for (int i = 0; i < 4000 && wq.size() != 0; i++) @(posedge clk);
		chk_val(16'(wq.size()), 16'h0000);
		chk_val(reg_addr, exp_ptr);
	endtask

	// ****************************************
	// register side responder and timeout
	// ****************************************
	always @(posedge clk) begin
		ws = lfsr(ws);
		reg_wready <= !hold_low && ws[0];
		// read data follows the pointer, taken in the reg_rd cycle
		reg_rdata <= rd_val(reg_addr);
		if (reg_rd)
			n_rd++;
		if (reg_wvalid) begin
			if (wq.size() == 0) begin
				chk_val(16'h0001, 16'h0000);
			end else begin
				e = wq.pop_front();
				chk_val({8'h00, reg_wdata}, {8'h00, e[7:0]});
				mem[e[23:8]] = e[7:0];
			end
		end
		cyc++;
		if (cyc == 60000) begin
			n_mismatch++;
			conclude();
		end
	end

	initial begin
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		for (int h = 0; h < 3; h++) begin
			for (int l = 0; l < 3; l++) begin
				port_select_pin_high <= 2'(h);
				port_select_pin_low <= 2'(l);
				dev = {I2CSCP_ADDR_HIGH, 3'(h * 3 + l)};
				repeat (3) @(posedge clk);
				chk_ack(port_active, !(h == 2 && l == 2));
				m.start();
				sendb({dev, 1'b0}, r[0]);
				chk_ack(r[0], !(h == 2 && l == 2));
				m.stop();
				m.start();
				sendb({dev + 7'h01, 1'b0}, r[0]);
				chk_ack(r[0], 1'b0);
				m.stop();
			end
		end
		port_select_pin_high <= I2CSCP_PIN_LOW;
		port_select_pin_low <= I2CSCP_PIN_OPEN;
		dev = {I2CSCP_ADDR_HIGH, 3'h1};
		repeat (3) @(posedge clk);
		set_ptr(16'hFFFE);
		wr_data(4, n);
		m.stop();
		drain();
		set_ptr(16'hFFFE);
		m.stop();
		rd_data(3);
		rd_data(2);
		set_ptr(16'h1234);
		rd_data(2);
		set_ptr(16'h0400);
		m.xfer(8'h3C, 4, r);
		rd_data(1);
		hold_low <= 1'b1;
		set_ptr(16'h0200);
		wr_data(40, n);
		m.stop();
		chk_ack(n == 32 || n == 33, 1'b1);
		hold_low <= 1'b0;
		drain();
		set_ptr(16'h0200);
		m.stop();
		rd_data(3);
		conclude();
	end
endmodule // test_i2c_slave_control_port
